// ---- src/dca_alu.sv ----
`timescale 1ns/1ps
`include "dca_map.svh"
module dca_alu #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic [15:0] accum_o, // accumulator, high:low byte
    output dca_pkg::dca_flags_t flags_o // flag register
);
    import dca_pkg::*;
    default clocking dca_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [15:0] acc_q, acc_d;
    logic [15:0] src_q, src_d;
    dca_flags_t flags_q, flags_d;
    logic [7:0] cmd_q, cmd_d;
    logic bad_q, bad_d;
    logic [31:0] prdata_q, prdata_d;

    logic acc_wr, acc_rd, mapped;
    logic [15:0] exe_acc;
    dca_flags_t exe_flags;
    logic exe_ok;
    logic need_adj;

    assign acc_wr = psel && penable && pwrite;
    // read data fetched in setup, so prdata leaves a flip-flop
    assign acc_rd = psel && !penable && !pwrite;
    assign mapped = paddr == ADDR_W'(`DCA_OFF_ACC)
        || paddr == ADDR_W'(`DCA_OFF_SRC)
        || paddr == ADDR_W'(`DCA_OFF_FLAGS)
        || paddr == ADDR_W'(`DCA_OFF_CMD)
        || paddr == ADDR_W'(`DCA_OFF_STAT);
    assign need_adj = (acc_q[3:0] > `DCA_DIGIT_MAX) || flags_q.aux_carry_flag;

    // execution of the command word on pwdata
    always_comb begin
        logic [7:0] lo;
        logic [7:0] hi;
        logic [16:0] sum;
        logic [15:0] a;
        logic [15:0] b;
        logic cin;
        logic word;
        lo = acc_q[7:0];
        hi = acc_q[15:8];
        sum = 17'h00000;
        word = pwdata[`DCA_CMD_WORD_BIT];
        cin = flags_q.carry_flag;
        a = word ? acc_q : {8'h00, acc_q[7:0]};
        b = word ? src_q : {8'h00, src_q[7:0]};
        exe_acc = acc_q;
        exe_flags = flags_q;
        // forms 0 to 5 (up to dca_form_acc_imm) are legal, 6 and 7 are refused; operands arrive already fetched
        exe_ok = pwdata[`DCA_CMD_FORM_LSB+:3] <= 3'(dca_form_acc_imm);
        unique case (pwdata[`DCA_CMD_OP_LSB+:3])
            3'(dca_op_adj_add): begin
                if (need_adj) begin
                    lo = lo + `DCA_DIGIT_FIX;
                    hi = hi + 8'h01;
                    exe_flags.aux_carry_flag = 1'b1;
                end
                exe_flags.carry_flag = exe_flags.aux_carry_flag;
                lo = lo & `DCA_NIBBLE_MASK;
                exe_acc = {hi, lo};
            end
            3'(dca_op_adj_sub): begin
                if (need_adj) begin
                    lo = lo - `DCA_DIGIT_FIX;
                    hi = hi - 8'h01;
                    exe_flags.aux_carry_flag = 1'b1;
                end
                exe_flags.carry_flag = exe_flags.aux_carry_flag;
                lo = lo & `DCA_NIBBLE_MASK;
                exe_acc = {hi, lo};
            end
            3'(dca_op_adj_div): begin
                lo = 8'(hi * `DCA_RADIX + lo);
                exe_acc = {8'h00, lo};
                exe_flags.parity_flag = ~^lo;
                exe_flags.sign_flag = lo[7];
                exe_flags.zero_flag = lo == 8'h00;
            end
            3'(dca_op_adj_mul): begin
                hi = acc_q[7:0] / `DCA_RADIX;
                lo = acc_q[7:0] % `DCA_RADIX;
                exe_acc = {hi, lo};
                exe_flags.parity_flag = ~^lo;
                exe_flags.sign_flag = lo[7];
                exe_flags.zero_flag = lo == 8'h00;
            end
            3'(dca_op_add_carry): begin
                sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
                exe_flags.aux_carry_flag = a[4] ^ b[4] ^ sum[4];
                exe_flags.parity_flag = ~^sum[7:0];
                if (word) begin
                    exe_acc = sum[15:0];
                    exe_flags.carry_flag = sum[16];
                    exe_flags.sign_flag = sum[15];
                    exe_flags.zero_flag = sum[15:0] == 16'h0000;
                    exe_flags.overflow_flag = (a[15] == b[15])
                        && (sum[15] != a[15]);
                end else begin
                    exe_acc = {acc_q[15:8], sum[7:0]};
                    exe_flags.carry_flag = sum[8];
                    exe_flags.sign_flag = sum[7];
                    exe_flags.zero_flag = sum[7:0] == 8'h00;
                    exe_flags.overflow_flag = (a[7] == b[7])
                        && (sum[7] != a[7]);
                end
            end
            default: begin
                exe_ok = 1'b0;
            end
        endcase
    end

    // register file next values
    always_comb begin
        acc_d = acc_q;
        src_d = src_q;
        flags_d = flags_q;
        cmd_d = cmd_q;
        bad_d = bad_q;
        if (acc_wr) begin
            unique case (paddr)
                ADDR_W'(`DCA_OFF_ACC): acc_d = pwdata[15:0];
                ADDR_W'(`DCA_OFF_SRC): src_d = pwdata[15:0];
                ADDR_W'(`DCA_OFF_FLAGS): begin
                    flags_d.carry_flag = pwdata[`DCA_BIT_CARRY];
                    flags_d.parity_flag = pwdata[`DCA_BIT_PARITY];
                    flags_d.aux_carry_flag = pwdata[`DCA_BIT_AUX];
                    flags_d.zero_flag = pwdata[`DCA_BIT_ZERO];
                    flags_d.sign_flag = pwdata[`DCA_BIT_SIGN];
                    flags_d.single_step_flag = pwdata[`DCA_BIT_STEP];
                    flags_d.int_enable_flag = pwdata[`DCA_BIT_IE];
                    flags_d.direction_flag = pwdata[`DCA_BIT_DIR];
                    flags_d.overflow_flag = pwdata[`DCA_BIT_OVF];
                end
                ADDR_W'(`DCA_OFF_CMD): begin
                    cmd_d = pwdata[7:0];
                    bad_d = !exe_ok;
                    // a refused command leaves the datapath untouched
                    if (exe_ok) begin
                        acc_d = exe_acc;
                        flags_d = exe_flags;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= `DCA_RST_ACC;
            src_q <= `DCA_RST_SRC;
            flags_q <= `DCA_RST_FLAGS;
            cmd_q <= `DCA_RST_CMD;
            bad_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            acc_q <= acc_d;
            src_q <= src_d;
            flags_q <= flags_d;
            cmd_q <= cmd_d;
            bad_q <= bad_d;
            prdata_q <= prdata_d;
        end
    end

    // zero wait states: every access completes in its first access cycle
    // no write lands between setup and access, so early fetch is safe
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (acc_rd) begin
            unique case (paddr)
                ADDR_W'(`DCA_OFF_ACC): prdata_d = {16'h0000, acc_q};
                ADDR_W'(`DCA_OFF_SRC): prdata_d = {16'h0000, src_q};
                ADDR_W'(`DCA_OFF_FLAGS): begin
                    prdata_d[`DCA_BIT_CARRY] = flags_q.carry_flag;
                    prdata_d[`DCA_BIT_PARITY] = flags_q.parity_flag;
                    prdata_d[`DCA_BIT_AUX] = flags_q.aux_carry_flag;
                    prdata_d[`DCA_BIT_ZERO] = flags_q.zero_flag;
                    prdata_d[`DCA_BIT_SIGN] = flags_q.sign_flag;
                    prdata_d[`DCA_BIT_STEP] = flags_q.single_step_flag;
                    prdata_d[`DCA_BIT_IE] = flags_q.int_enable_flag;
                    prdata_d[`DCA_BIT_DIR] = flags_q.direction_flag;
                    prdata_d[`DCA_BIT_OVF] = flags_q.overflow_flag;
                end
                ADDR_W'(`DCA_OFF_CMD): prdata_d = {24'h000000, cmd_q};
                ADDR_W'(`DCA_OFF_STAT): prdata_d = {31'h0000_0000, bad_q};
                default: begin
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    // status is read-only, so a write to it is an error too
    assign pslverr = psel && penable
        && (!mapped || (pwrite && paddr == ADDR_W'(`DCA_OFF_STAT)));
    assign accum_o = acc_q;
    assign flags_o = flags_q;

    logic cmd_wr;
    logic [2:0] cmd_op;
    assign cmd_wr = acc_wr && paddr == ADDR_W'(`DCA_OFF_CMD) && exe_ok;
    assign cmd_op = pwdata[`DCA_CMD_OP_LSB+:3];

    a_add_adjust: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_add) && need_adj
        |=> flags_q.aux_carry_flag
            && acc_q[15:8] == $past(acc_q[15:8]) + 8'h01
            && acc_q[3:0] == 4'($past(acc_q[3:0]) + 4'h6))
        else $error("adjust-add step wrong");
    a_add_plain: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_add) && !need_adj
        |=> acc_q == {$past(acc_q[15:8]), 4'h0, $past(acc_q[3:0])}
            && !flags_q.carry_flag)
        else $error("adjust-add without step wrong");
    a_add_mask: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_add)
        |=> acc_q[7:4] == 4'h0
            && flags_q.carry_flag == flags_q.aux_carry_flag)
        else $error("adjust-add mask or carry wrong");
    a_sub_adjust: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_sub) && need_adj
        |=> flags_q.aux_carry_flag
            && acc_q[15:8] == $past(acc_q[15:8]) - 8'h01
            && acc_q[3:0] == 4'($past(acc_q[3:0]) - 4'h6))
        else $error("adjust-subtract step wrong");
    a_sub_plain: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_sub) && !need_adj
        |=> acc_q == {$past(acc_q[15:8]), 4'h0, $past(acc_q[3:0])}
            && !flags_q.carry_flag)
        else $error("adjust-subtract without step wrong");
    a_sub_mask: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_sub)
        |=> acc_q[7:4] == 4'h0
            && flags_q.carry_flag == flags_q.aux_carry_flag)
        else $error("adjust-subtract mask or carry wrong");
    a_div_result: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_div)
        |=> acc_q[15:8] == 8'h00
            && acc_q[7:0] == 8'($past(acc_q[15:8]) * 8'h0A
                + $past(acc_q[7:0]))
            && flags_q.parity_flag == ~^acc_q[7:0])
        else $error("adjust-divide result wrong");
    a_mul_result: assert property (
        cmd_wr && cmd_op == 3'(dca_op_adj_mul)
        |=> acc_q[7:0] < 8'h0A
            && 8'(acc_q[15:8] * 8'h0A + acc_q[7:0]) == $past(acc_q[7:0])
            && flags_q.zero_flag == (acc_q[7:0] == 8'h00))
        else $error("adjust-multiply result wrong");
    a_carry_sum: assert property (
        cmd_wr && cmd_op == 3'(dca_op_add_carry) && pwdata[`DCA_CMD_WORD_BIT]
        |=> {flags_q.carry_flag, acc_q} == {1'b0, $past(acc_q)}
            + {1'b0, $past(src_q)} + {16'h0000, $past(flags_q.carry_flag)})
        else $error("word add-with-carry wrong");
    a_carry_byte: assert property (
        cmd_wr && cmd_op == 3'(dca_op_add_carry) && !pwdata[`DCA_CMD_WORD_BIT]
        |=> acc_q[15:8] == $past(acc_q[15:8])
            && {flags_q.carry_flag, acc_q[7:0]} == {1'b0, $past(acc_q[7:0])}
            + {1'b0, $past(src_q[7:0])} + {8'h00, $past(flags_q.carry_flag)})
        else $error("byte add-with-carry wrong");
    a_carry_aux: assert property (
        cmd_wr && cmd_op == 3'(dca_op_add_carry)
        |=> flags_q.aux_carry_flag == 1'((5'($past(acc_q[3:0]))
            + 5'($past(src_q[3:0])) + 5'($past(flags_q.carry_flag))) >> 4))
        else $error("add-with-carry aux carry wrong");
    a_carry_parity: assert property (
        cmd_wr && cmd_op == 3'(dca_op_add_carry)
        |=> flags_q.parity_flag == ~^acc_q[7:0])
        else $error("add-with-carry parity wrong");
    a_refused_cmd: assert property (
        acc_wr && paddr == ADDR_W'(`DCA_OFF_CMD) && !exe_ok
        |=> acc_q == $past(acc_q) && flags_q == $past(flags_q) && bad_q)
        else $error("refused command changed state");
    a_fixed_flags: assert property (
        cmd_wr
        |=> flags_q.direction_flag == $past(flags_q.direction_flag)
            && flags_q.int_enable_flag == $past(flags_q.int_enable_flag)
            && flags_q.single_step_flag == $past(flags_q.single_step_flag))
        else $error("control flag changed by command");

endmodule

// ---- src/dca_map.svh ----
`ifndef DCA_MAP_SVH
`define DCA_MAP_SVH

// register byte offsets
`define DCA_OFF_ACC 8'h00
`define DCA_OFF_SRC 8'h04
`define DCA_OFF_FLAGS 8'h08
`define DCA_OFF_CMD 8'h0C
`define DCA_OFF_STAT 8'h10

// reset values
`define DCA_RST_ACC 16'h0000
`define DCA_RST_SRC 16'h0000
`define DCA_RST_CMD 8'h00
`define DCA_RST_FLAGS 9'h000

// flag bit positions in the flags register
`define DCA_BIT_CARRY 0
`define DCA_BIT_PARITY 2
`define DCA_BIT_AUX 4
`define DCA_BIT_ZERO 6
`define DCA_BIT_SIGN 7
`define DCA_BIT_STEP 8
`define DCA_BIT_IE 9
`define DCA_BIT_DIR 10
`define DCA_BIT_OVF 11

// command register fields
`define DCA_CMD_OP_LSB 0
`define DCA_CMD_WORD_BIT 3
`define DCA_CMD_FORM_LSB 4

// decimal adjust constants
`define DCA_DIGIT_MAX 4'h9
`define DCA_DIGIT_FIX 8'h06
`define DCA_RADIX 8'h0A
`define DCA_NIBBLE_MASK 8'h0F

`endif

// ---- src/dca_pkg.sv ----
package dca_pkg;

    typedef enum logic [2:0] {
        dca_op_adj_add = 3'h0,
        dca_op_adj_sub = 3'h1,
        dca_op_adj_div = 3'h2,
        dca_op_adj_mul = 3'h3,
        dca_op_add_carry = 3'h4
    } dca_op_t;

    typedef enum logic [2:0] {
        dca_form_reg_reg = 3'h0,
        dca_form_reg_mem = 3'h1,
        dca_form_mem_reg = 3'h2,
        dca_form_reg_imm = 3'h3,
        dca_form_mem_imm = 3'h4,
        dca_form_acc_imm = 3'h5
    } dca_form_t;

    typedef struct packed {
        logic overflow_flag;
        logic direction_flag;
        logic int_enable_flag;
        logic single_step_flag;
        logic sign_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic parity_flag;
        logic carry_flag;
    } dca_flags_t;

endpackage

// ---- dv/test_decimal_adjust_and_add_carry_alu.sv ----
`timescale 1ns/1ps
`include "dca_map.svh"
module test_decimal_adjust_and_add_carry_alu;
    import dca_pkg::*;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] msk;
        logic err;
        logic acc;
        logic flg;
    } dca_note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] accum_o;
    dca_flags_t flags_o;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] rng = 32'h5315D3AE;
    dca_note_t q[$];
    dca_note_t mon_note;

    dca_alu #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .accum_o(accum_o), .flags_o(flags_o));

    always #5 pclk = ~pclk;

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // flags output laid out as the flags register image
    function automatic logic [31:0] flg_img(input dca_flags_t f);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`DCA_BIT_CARRY] = f.carry_flag;
        v[`DCA_BIT_PARITY] = f.parity_flag;
        v[`DCA_BIT_AUX] = f.aux_carry_flag;
        v[`DCA_BIT_ZERO] = f.zero_flag;
        v[`DCA_BIT_SIGN] = f.sign_flag;
        v[`DCA_BIT_STEP] = f.single_step_flag;
        v[`DCA_BIT_IE] = f.int_enable_flag;
        v[`DCA_BIT_DIR] = f.direction_flag;
        v[`DCA_BIT_OVF] = f.overflow_flag;
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input logic [31:0] msk);
        num_checks++;
        if ((got & msk) !== (exp & msk)) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one note per transfer, taken at the edge that completes it
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready) begin
            if (q.size() == 0) begin
                failures++;
                $display("MISMATCH t=%0t unexpected transfer", $time);
            end else begin
                mon_note = q.pop_front();
                chk(prdata, mon_note.exp, mon_note.msk);
                chk({31'h0, pslverr}, {31'h0, mon_note.err}, 32'h1);
                if (mon_note.acc)
                    chk({16'h0, accum_o}, mon_note.exp, 32'hFFFF);
                if (mon_note.flg)
                    chk(flg_img(flags_o), mon_note.exp, mon_note.msk);
            end
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop;
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic [31:0] m, input logic er);
        q.push_back('{e, m, er, (!wr && a == `DCA_OFF_ACC),
            (!wr && a == `DCA_OFF_FLAGS)});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for pready
        do begin
            @(posedge pclk);
        end while (!pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic er);
        apb(1'b1, a, d, 32'h0, 32'h0, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic er);
        apb(1'b0, a, 32'h0, e, m, er);
    endtask

    // flags held as the 12-bit register image; fm marks defined flags
    task automatic model(input logic [2:0] op, input logic wd,
                         input logic [15:0] acc, input logic [15:0] src,
                         input logic [11:0] f, output logic [15:0] ra,
                         output logic [11:0] rf, output logic [11:0] fm);
        logic [7:0] lb;
        logic [7:0] hb;
        logic [16:0] s;
        logic [4:0] lo;
        lb = acc[7:0];
        hb = acc[15:8];
        rf = f;
        fm = 12'hFD5;
        if (op <= 3'h1) begin
            if (lb[3:0] > 4'h9 || f[`DCA_BIT_AUX]) begin
                lb = (op == 3'h0) ? lb + 8'h06 : lb - 8'h06;
                hb = (op == 3'h0) ? hb + 8'h01 : hb - 8'h01;
                rf[`DCA_BIT_AUX] = 1'b1;
            end
            rf[`DCA_BIT_CARRY] = rf[`DCA_BIT_AUX];
            lb = lb & 8'h0F;
            fm = 12'h711;
        end else if (op <= 3'h3) begin
            if (op == 3'h2) begin
                lb = hb * 8'h0A + lb;
                hb = 8'h00;
            end else begin
                hb = lb / 8'h0A;
                lb = lb % 8'h0A;
            end
            rf[`DCA_BIT_SIGN] = lb[7];
            rf[`DCA_BIT_ZERO] = (lb == 8'h00);
            rf[`DCA_BIT_PARITY] = ~^lb;
            fm = 12'h7C4;
        end else begin
            lo = acc[3:0] + src[3:0] + f[`DCA_BIT_CARRY];
            rf[`DCA_BIT_AUX] = lo[4];
            if (wd) begin
                s = acc + src + f[`DCA_BIT_CARRY];
                {hb, lb} = s[15:0];
                rf[`DCA_BIT_OVF] = acc[15] == src[15] && s[15] != acc[15];
            end else begin
                s = lb + src[7:0] + f[`DCA_BIT_CARRY];
                s[16] = s[8];
                lb = s[7:0];
                rf[`DCA_BIT_OVF] = acc[7] == src[7] && s[7] != acc[7];
            end
            rf[`DCA_BIT_CARRY] = s[16];
            rf[`DCA_BIT_SIGN] = wd ? hb[7] : lb[7];
            rf[`DCA_BIT_ZERO] = wd ? {hb, lb} == 16'h0 : lb == 8'h00;
            rf[`DCA_BIT_PARITY] = ~^lb;
        end
        ra = {hb, lb};
    endtask

    initial begin
        logic [15:0] acc;
        logic [15:0] src;
        logic [11:0] fl;
        logic [15:0] ra;
        logic [11:0] rf;
        logic [11:0] fm;
        logic [7:0] cmd;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(8'h00 + 8'(4 * i), 32'h0, 32'hFFFFFFFF, 1'b0);
        wr(`DCA_OFF_FLAGS, 32'hFFFFFFFF, 1'b0);
        rd(`DCA_OFF_FLAGS, 32'hFD5, 32'hFFFFFFFF, 1'b0);
        $display("test reset and access done");
        for (int i = 0; i < 240; i++) begin
            acc = 16'(next_rand());
            src = 16'(next_rand());
            fl = 12'(next_rand() & 32'hFD5);
            cmd = {1'b0, 3'(i / 5 % 6), rng[9], 3'(i % 5)};
            wr(`DCA_OFF_ACC, {16'h0, acc}, 1'b0);
            wr(`DCA_OFF_SRC, {16'h0, src}, 1'b0);
            wr(`DCA_OFF_FLAGS, {20'h0, fl}, 1'b0);
            wr(`DCA_OFF_CMD, {24'h0, cmd}, 1'b0);
            model(cmd[2:0], cmd[3], acc, src, fl, ra, rf, fm);
            rd(`DCA_OFF_ACC, {16'h0, ra}, 32'hFFFFFFFF, 1'b0);
            rd(`DCA_OFF_FLAGS, {20'h0, rf}, {20'hFFFFF, fm}, 1'b0);
            rd(`DCA_OFF_STAT, 32'h0, 32'hFFFFFFFF, 1'b0);
            rd(`DCA_OFF_CMD, {24'h0, cmd}, 32'hFFFFFFFF, 1'b0);
        end
        $display("test instruction sweep done");
        for (int j = 0; j < 5; j++) begin
            cmd = (j < 3) ? 8'(j + 5) : {1'b0, 3'(j + 3), 4'h4};
            wr(`DCA_OFF_CMD, {24'h0, cmd}, 1'b0);
            rd(`DCA_OFF_ACC, {16'h0, ra}, 32'hFFFFFFFF, 1'b0);
            rd(`DCA_OFF_FLAGS, {20'h0, rf}, {20'hFFFFF, fm}, 1'b0);
            rd(`DCA_OFF_STAT, 32'h1, 32'hFFFFFFFF, 1'b0);
        end
        $display("test illegal command done");
        rd(8'h14, 32'h0, 32'hFFFFFFFF, 1'b1);
        wr(`DCA_OFF_STAT, 32'h0, 1'b1);
        wr(8'h20, 32'h0, 1'b1);
        rd(`DCA_OFF_STAT, 32'h1, 32'hFFFFFFFF, 1'b0);
        $display("test unmapped access done");
        @(posedge pclk);
        chk(32'(q.size()), 32'h0, 32'hFFFFFFFF);
        report_and_stop;
    end
endmodule
